// ==== bim_adc_model.sv ====
// Purpose: converter stand-in answering conversion requests
// Assumes: start is a one-cycle pulse
// Notes: results are only valid with the done pulse
`timescale 1ns/10ps
`default_nettype none
module bim_adc_model #(
  parameter int unsigned DLY  = 40,
  parameter logic [15:0] VOLT = 16'h0e10,
  parameter logic [15:0] TEMP = 16'h0190
) (
  input  wire logic        clk_i,   // clock
  input  wire logic        start_i, // conversion request
  output logic             done_o,  // results ready pulse
  output logic      [15:0] volt_o,  // voltage result
  output logic      [15:0] temp_o   // temperature result
);
  int cnt = 0;
  initial done_o = 1'b0;
  // outside the done cycle the results show inverted garbage
  always @(posedge clk_i) begin
    done_o <= (cnt == 1);
    volt_o <= (cnt == 1) ? VOLT : ~VOLT;
    temp_o <= (cnt == 1) ? TEMP : ~TEMP;
    cnt    <= start_i ? DLY : ((cnt > 0) ? cnt - 1 : 0);
  end
endmodule : bim_adc_model
`default_nettype wire

// ==== bim_ctrl.sv ====
// Purpose: register file, identifier programming, key gating and power modes
// Assumes: word-level access strobes from a serial front end, synchronous to clk_i
// Notes: an access is answered one cycle later on ack_o/nack_o and rdata_o
`timescale 1ns/10ps
`default_nettype none
module bim_ctrl
  import bim_pkg::*;
(
  input  wire logic        clk_i,        // system clock
  input  wire logic        rst_i,        // sync reset, active high
  input  wire logic        pack_en_i,    // pack enable pin, active high
  input  wire logic        wr_i,         // word write strobe
  input  wire logic        rd_i,         // word read strobe
  input  wire logic        burst_i,      // access reached by auto-increment
  input  wire logic [7:0]  addr_i,       // register address
  input  wire logic [15:0] wdata_i,      // write data
  input  wire logic        conv_done_i,  // both conversions finished
  input  wire logic [15:0] volt_i,       // voltage result
  input  wire logic [15:0] temp_i,       // temperature result
  output logic      [15:0] rdata_o,      // read data
  output logic             ack_o,        // access accepted, pulse
  output logic             nack_o,       // access refused, pulse
  output logic      [1:0]  mode_o,       // power mode
  output logic             conv_start_o, // start conversions, pulse
  output logic             power_on_o,   // bandgap, oscillator, regulator on
  output logic             mismatch_o,   // identifier shadow disagreement
  output logic             unlocked_o    // identifier writes enabled
);
  typedef struct packed {
    logic [NUM_USER-1:0][15:0] user;
    logic [15:0]               key_up;
    logic [15:0]               key_lo;
    logic [NUM_ID-1:0][63:0]   stage;
    logic [15:0]               volt;
    logic [15:0]               temp;
    logic                      unlocked;
    logic                      wake;
    logic                      mism;
    bim_mode_t                 mode;
    logic [31:0]               tmr;
    logic                      prog;
    logic [15:0]               rdata;
    logic                      ack;
    logic                      nack;
    logic                      conv_start;
    logic                      power_on;
  } bim_ctrl_st_t;

  bim_ctrl_st_t s_q, s_d;

  logic [NUM_ID-1:0][63:0] id_w;
  logic [NUM_ID-1:0]       id_mis_w;
  logic [NUM_ID-1:0]       id_burn_w;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ID; gi++) begin : g_id
      bim_otp_id u_id (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .prog_i     (s_q.prog),
        .value_i    (s_q.stage[gi]),
        .id_o       (id_w[gi]),
        .mismatch_o (id_mis_w[gi]),
        .burned_o   (id_burn_w[gi])
      );
    end
  endgenerate

  logic        key_ok;
  logic        in_user, in_id, legal;
  logic [3:0]  uidx;
  logic [2:0]  iidx;
  logic [15:0] stat;

  always_comb begin
    key_ok  = ({s_q.key_up, s_q.key_lo} == KEY_DEFAULT);
    in_user = (addr_i >= A_USER_LO) && (addr_i <= A_USER_HI);
    in_id   = (addr_i >= A_ID_LO) && (addr_i <= A_ID_HI);
    uidx    = 4'(addr_i - A_USER_LO);
    iidx    = 3'(addr_i - A_ID_LO);
    legal   = in_user || in_id || (addr_i == A_KEY_UP) || (addr_i == A_KEY_LO) ||
              (addr_i == A_CTRL) || (addr_i == A_STATUS) || (addr_i == A_VOLT) ||
              (addr_i == A_TEMP);
    stat    = ZERO16;
    stat[ST_UNLOCKED] = s_q.unlocked;
    stat[ST_MISMATCH] = s_q.mism;
    stat[ST_PRG_DONE] = |id_burn_w;
    stat[ST_ID0_PRG]  = id_burn_w[0];
    stat[ST_ID1_PRG]  = id_burn_w[1];

    s_d            = s_q;
    s_d.ack        = 1'b0;
    s_d.nack       = 1'b0;
    s_d.prog       = 1'b0;
    s_d.conv_start = 1'b0;

    if (|id_mis_w) begin
      s_d.mism = 1'b1;
    end

    if (wr_i) begin
      if (!legal) begin
        s_d.nack = 1'b1;
      end else if (in_user) begin
        s_d.user[uidx] = wdata_i;
        s_d.ack = 1'b1;
      end else if (addr_i == A_KEY_UP) begin
        s_d.key_up = wdata_i;
        s_d.ack = 1'b1;
      end else if (addr_i == A_KEY_LO) begin
        s_d.key_lo = wdata_i;
        s_d.ack = 1'b1;
      end else if (in_id) begin
        if (s_q.unlocked) begin
          s_d.stage[iidx[2]][iidx[1:0]*16 +: 16] = wdata_i;
          s_d.ack = 1'b1;
        end else begin
          s_d.nack = 1'b1;
        end
      end else if (addr_i == A_CTRL) begin
        s_d.ack = 1'b1;
        if (wdata_i == CMD_UNLOCK && key_ok) begin
          s_d.unlocked = 1'b1;
        end else if (wdata_i == CMD_LOCK && key_ok) begin
          s_d.unlocked = 1'b0;
        end else if (wdata_i == CMD_PROGRAM && s_q.unlocked) begin
          s_d.prog = 1'b1;
        end else if (wdata_i == CMD_MEASURE && s_q.mode == BIM_STANDBY) begin
          s_d.mode = BIM_ACTIVE;
          s_d.tmr  = MEAS_CYC;
          s_d.conv_start = 1'b1;
        end else if (wdata_i == CMD_WAKE) begin
          s_d.wake = 1'b1;
        end else if (wdata_i == CMD_SLEEP) begin
          s_d.wake = 1'b0;
        end
      end else begin
        s_d.nack = 1'b1;
      end
    end else if (rd_i) begin
      if (!legal) begin
        s_d.rdata = RD_FILL;
        if (burst_i) begin
          s_d.ack = 1'b1;
        end else begin
          s_d.nack = 1'b1;
        end
      end else begin
        s_d.ack = 1'b1;
        if (in_user) begin
          s_d.rdata = s_q.user[uidx];
        end else if (in_id) begin
          s_d.rdata = id_w[iidx[2]][iidx[1:0]*16 +: 16];
        end else if (addr_i == A_KEY_UP) begin
          s_d.rdata = s_q.key_up;
        end else if (addr_i == A_KEY_LO) begin
          s_d.rdata = s_q.key_lo;
        end else if (addr_i == A_STATUS) begin
          s_d.rdata = stat;
        end else if (addr_i == A_VOLT) begin
          s_d.rdata = s_q.volt;
        end else if (addr_i == A_TEMP) begin
          s_d.rdata = s_q.temp;
        end else begin
          s_d.rdata = ZERO16;
        end
      end
    end

    // power mode sequencing
    case (s_q.mode)
      BIM_SHUTDOWN: begin
        if (pack_en_i) begin
          s_d.mode = BIM_STANDBY;
        end
      end
      BIM_STANDBY: begin
        // registers stay accessible here
      end
      BIM_ACTIVE: begin
        if (conv_done_i || s_q.tmr == 32'h0000_0000) begin
          s_d.volt = volt_i;
          s_d.temp = temp_i;
          s_d.mode = BIM_STANDBY;
        end else begin
          s_d.tmr = s_q.tmr - 32'h0000_0001;
        end
      end
      default: begin
        s_d.mode = BIM_SHUTDOWN;
      end
    endcase

    if (!pack_en_i) begin
      s_d.mode = BIM_SHUTDOWN;
      s_d.wake = 1'b0;
      s_d.conv_start = 1'b0;
    end
    s_d.power_on = pack_en_i && (s_d.wake || s_d.mode == BIM_ACTIVE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q      <= '0;
      s_q.mode <= BIM_SHUTDOWN;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o      = s_q.rdata;
  assign ack_o        = s_q.ack;
  assign nack_o       = s_q.nack;
  assign mode_o       = s_q.mode;
  assign conv_start_o = s_q.conv_start;
  assign power_on_o   = s_q.power_on;
  assign mismatch_o   = s_q.mism;
  assign unlocked_o   = s_q.unlocked;
endmodule : bim_ctrl
`default_nettype wire

// ==== bim_ctrl_props.sv ====
// Purpose: port assertions for the control block
// Assumes: one clock, sync reset high
// Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module bim_ctrl_props
  import bim_pkg::*;
(
  input wire logic        clk_i,        // clock
  input wire logic        rst_i,        // reset
  input wire logic        pack_en_i,    // enable pin
  input wire logic        wr_i,         // write
  input wire logic        rd_i,         // read
  input wire logic        burst_i,      // burst
  input wire logic [7:0]  addr_i,       // address
  input wire logic [15:0] wdata_i,      // wdata
  input wire logic        conv_done_i,  // done
  input wire logic [15:0] volt_i,       // volt
  input wire logic [15:0] temp_i,       // temp
  input wire logic [15:0] rdata_o,      // rdata
  input wire logic        ack_o,        // ack
  input wire logic        nack_o,       // nack
  input wire logic [1:0]  mode_o,       // mode
  input wire logic        conv_start_o, // start
  input wire logic        power_on_o,   // power
  input wire logic        mismatch_o,   // mismatch
  input wire logic        unlocked_o    // unlocked
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_meas;
    wr_i && addr_i == A_CTRL && wdata_i == CMD_MEASURE && pack_en_i && mode_o == 2'h1;
  endsequence
  sequence s_act;
    mode_o == 2'h2 && conv_start_o;
  endsequence
  AST_ANSWER: assert property ((wr_i || rd_i) |=> ack_o != nack_o)
    else $error("access not answered once");
  AST_BAD_RD: assert property (rd_i && !burst_i && addr_i > A_ID_HI |=> nack_o)
    else $error("illegal read not refused");
  AST_FILL: assert property (rd_i && burst_i && addr_i > A_ID_HI |=> ack_o && rdata_o == RD_FILL)
    else $error("burst read past range not filled");
  AST_MEAS: assert property (s_meas |=> s_act)
    else $error("measure did not enter active");
  AST_DONE: assert property (mode_o == 2'h2 && conv_done_i && pack_en_i |=> mode_o == 2'h1)
    else $error("no return to standby");
  AST_SHUT: assert property (!pack_en_i |=> mode_o == 2'h0 && !power_on_o)
    else $error("enable low without shutdown");
  AST_WAKE: assert property (wr_i && addr_i == A_CTRL && wdata_i == CMD_WAKE && pack_en_i |=> power_on_o)
    else $error("wake did not power up");
  AST_HOLD: assert property (power_on_o && mode_o == 2'h1 && pack_en_i && !wr_i |=> power_on_o)
    else $error("wake power dropped");
  AST_LOCKED: assert property (wr_i && !unlocked_o && addr_i inside {[A_ID_LO:A_ID_HI]} |=> nack_o)
    else $error("locked identifier write accepted");
endmodule : bim_ctrl_props
bind bim_ctrl bim_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .pack_en_i(pack_en_i), .wr_i(wr_i),
  .rd_i(rd_i), .burst_i(burst_i), .addr_i(addr_i), .wdata_i(wdata_i), .conv_done_i(conv_done_i),
  .volt_i(volt_i), .temp_i(temp_i), .rdata_o(rdata_o), .ack_o(ack_o), .nack_o(nack_o), .mode_o(mode_o),
  .conv_start_o(conv_start_o), .power_on_o(power_on_o), .mismatch_o(mismatch_o), .unlocked_o(unlocked_o));
`default_nettype wire

// ==== bim_otp_id.sv ====
// Purpose: one-time identifier store with shadow copy and readback compare
// Assumes: prog_i is a one-cycle pulse
// Notes: both copies are written by the same pulse and not again until rst_i clears them
`timescale 1ns/10ps
`default_nettype none
module bim_otp_id
  import bim_pkg::*;
(
  input  wire logic        clk_i,      // system clock
  input  wire logic        rst_i,      // sync reset, active high
  input  wire logic        prog_i,     // program pulse
  input  wire logic [63:0] value_i,    // staged value to burn
  output logic      [63:0] id_o,       // primary copy
  output logic             mismatch_o, // copies differ
  output logic             burned_o    // already programmed
);
  typedef struct packed {
    logic [63:0] main;
    logic [63:0] shadow;
    logic        burned;
  } bim_otp_st_t;

  bim_otp_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (prog_i && !s_q.burned) begin
      s_d.main   = value_i;
      s_d.shadow = value_i;
      s_d.burned = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign id_o       = s_q.main;
  assign mismatch_o = (s_q.main != s_q.shadow);
  assign burned_o   = s_q.burned;
endmodule : bim_otp_id
`default_nettype wire

// ==== bim_pkg.sv ====
// Purpose: shared constants for the battery id monitor control block
// Assumes: host register traffic arrives as decoded word accesses, one address per 16-bit word
// Notes:
package bim_pkg;
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned MEAS_TIME_MS  = 28;
  localparam longint unsigned MEAS_CYC_L = (longint'(CLK_HZ) * MEAS_TIME_MS) / 1000;
  // timeout reload: results land one cycle inside the limit, not on it
  localparam int unsigned MEAS_CYC      = 32'(MEAS_CYC_L - 2);

  localparam logic [7:0] A_USER_LO   = 8'h08;
  localparam logic [7:0] A_USER_HI   = 8'h13;
  localparam logic [7:0] A_KEY_UP    = 8'h06;
  localparam logic [7:0] A_KEY_LO    = 8'h07;
  localparam logic [7:0] A_CTRL      = 8'h05;
  localparam logic [7:0] A_STATUS    = 8'h04;
  localparam logic [7:0] A_VOLT      = 8'h02;
  localparam logic [7:0] A_TEMP      = 8'h03;
  localparam logic [7:0] A_ID_LO     = 8'h20;
  localparam logic [7:0] A_ID_HI     = 8'h27;

  localparam logic [15:0] CMD_UNLOCK  = 16'h00a5;
  localparam logic [15:0] CMD_LOCK    = 16'h005a;
  localparam logic [15:0] CMD_PROGRAM = 16'h00c3;
  localparam logic [15:0] CMD_MEASURE = 16'h0001;
  localparam logic [15:0] CMD_WAKE    = 16'h0010;
  localparam logic [15:0] CMD_SLEEP   = 16'h0020;

  localparam logic [31:0] KEY_DEFAULT = 32'h1234_5678;
  localparam logic [15:0] RD_FILL     = 16'hffff;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam int unsigned NUM_USER    = 12;
  localparam int unsigned NUM_ID      = 2;

  localparam int unsigned ST_UNLOCKED = 0;
  localparam int unsigned ST_MISMATCH = 1;
  localparam int unsigned ST_PRG_DONE = 2;
  localparam int unsigned ST_ID0_PRG  = 3;
  localparam int unsigned ST_ID1_PRG  = 4;

  typedef enum logic [1:0] {
    BIM_SHUTDOWN,
    BIM_STANDBY,
    BIM_ACTIVE
  } bim_mode_t;
endpackage : bim_pkg

// ==== tb_battery_id_monitor_control.sv ====
// Purpose: self-checking bench for the control block
// Assumes: word accesses answered one cycle after they are taken
// Notes: converter modelled by bim_adc_model
`timescale 1ns/10ps
`default_nettype none
module tb_battery_id_monitor_control;
  import bim_pkg::*;
  logic        clk_i = 0, rst_i = 1, pack_en_i = 1, wr_i = 0, rd_i = 0, burst_i = 0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, volt, temp, rdata_o, rd;
  logic        done, ack_o, nack_o, conv_start_o, power_on_o, mismatch_o, unlocked_o, ak, nk;
  logic [1:0]  mode_o;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  initial forever #4 clk_i = ~clk_i;
  bim_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .pack_en_i(pack_en_i), .wr_i(wr_i), .rd_i(rd_i),
    .burst_i(burst_i), .addr_i(addr_i), .wdata_i(wdata_i), .conv_done_i(done), .volt_i(volt),
    .temp_i(temp), .rdata_o(rdata_o), .ack_o(ack_o), .nack_o(nack_o), .mode_o(mode_o),
    .conv_start_o(conv_start_o), .power_on_o(power_on_o), .mismatch_o(mismatch_o), .unlocked_o(unlocked_o));
  bim_adc_model #(.DLY(40)) u_adc (.clk_i(clk_i), .start_i(conv_start_o), .done_o(done), .volt_o(volt),
    .temp_o(temp));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(bit w, bit b, logic [7:0] a, logic [15:0] d, bit ex);
    @(posedge clk_i);
    {wr_i, rd_i, burst_i, addr_i, wdata_i} <= {w, !w, b, a, d};
    @(posedge clk_i);
    {wr_i, rd_i, burst_i} <= 3'h0;
    #1;
    rd = rdata_o;
    chk("answer", 16'({ack_o, nack_o}), ex ? 16'h2 : 16'h1);
  endtask : acc
  task automatic t_user;
    for (int k = 0; k < NUM_USER; k++) acc(1, 0, A_USER_LO + 8'(k), 16'ha500 + 16'(k), 1);
    for (int k = 0; k < NUM_USER; k++) begin
      acc(0, 0, A_USER_LO + 8'(k), 16'h0, 1);
      chk("user", rd, 16'ha500 + 16'(k));
    end
    acc(0, 0, 8'h30, 16'h0, 0);
    acc(1, 1, 8'h28, 16'h0, 0);
    acc(0, 1, 8'h30, 16'h0, 1);
    chk("fill", rd, RD_FILL);
  endtask : t_user
  task automatic t_meas;
    chk("standby", 16'(mode_o), 16'h1);
    acc(1, 0, A_CTRL, CMD_MEASURE, 1);
    chk("active", 16'({mode_o, conv_start_o}), 16'h5);
    repeat (100) begin
      @(posedge clk_i);
      #1;
      if (mode_o === 2'h1) break;
    end
    chk("back", 16'(mode_o), 16'h1);
    acc(0, 0, A_VOLT, 16'h0, 1);
    chk("volt", rd, 16'h0e10);
    acc(0, 0, A_TEMP, 16'h0, 1);
    chk("temp", rd, 16'h0190);
  endtask : t_meas
  task automatic t_id;
    acc(1, 0, A_ID_LO, 16'h1111, 0);
    acc(1, 0, A_KEY_UP, 16'h0000, 1);
    acc(1, 0, A_KEY_LO, KEY_DEFAULT[15:0], 1);
    acc(1, 0, A_CTRL, CMD_UNLOCK, 1);
    chk("badkey", 16'(unlocked_o), 16'h0);
    acc(1, 0, A_KEY_UP, KEY_DEFAULT[31:16], 1);
    acc(1, 0, A_CTRL, CMD_UNLOCK, 1);
    chk("unlock", 16'(unlocked_o), 16'h1);
    for (int k = 0; k < 8; k++) acc(1, 0, A_ID_LO + 8'(k), 16'hb000 + 16'(k), 1);
    acc(1, 0, A_CTRL, CMD_PROGRAM, 1);
    repeat (50) begin
      acc(0, 0, A_STATUS, 16'h0, 1);
      if (rd[4:3] === 2'h3) break;
    end
    chk("status", rd & 16'h001f, 16'h001d);
    // wrong key must not relock; a second burn while unlocked must not overwrite
    acc(1, 0, A_KEY_LO, 16'h0000, 1);
    acc(1, 0, A_CTRL, CMD_LOCK, 1);
    chk("badlock", 16'(unlocked_o), 16'h1);
    acc(1, 0, A_ID_LO, 16'hffff, 1);
    acc(1, 0, A_CTRL, CMD_PROGRAM, 1);
    acc(1, 0, A_KEY_LO, KEY_DEFAULT[15:0], 1);
    acc(1, 0, A_CTRL, CMD_LOCK, 1);
    chk("lock", 16'(unlocked_o), 16'h0);
    acc(1, 0, A_ID_LO, 16'hffff, 0);
    acc(1, 0, A_CTRL, CMD_PROGRAM, 1);
    for (int k = 0; k < 8; k++) begin
      acc(0, 0, A_ID_LO + 8'(k), 16'h0, 1);
      chk("id", rd, 16'hb000 + 16'(k));
    end
    chk("shadow", 16'(mismatch_o), 16'h0);
  endtask : t_id
  task automatic t_pwr;
    acc(1, 0, A_CTRL, CMD_WAKE, 1);
    repeat (20) @(posedge clk_i);
    #1;
    chk("wake", 16'(power_on_o), 16'h1);
    acc(1, 0, A_CTRL, CMD_SLEEP, 1);
    chk("sleep", 16'(power_on_o), 16'h0);
    @(posedge clk_i) pack_en_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("shut", 16'({mode_o, power_on_o}), 16'h0);
    @(posedge clk_i) pack_en_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("resume", 16'(mode_o), 16'h1);
  endtask : t_pwr
  task automatic wrap_up;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    t_meas();
    t_user();
    t_id();
    t_pwr();
    wrap_up();
  end
endmodule : tb_battery_id_monitor_control
`default_nettype wire
